// *** inc/ssp_consts.vh ***
`ifndef SSP_CONSTS_VH
`define SSP_CONSTS_VH

// register offsets
`define SSP_A_DATA    8'h00
`define SSP_A_CTRL    8'h04
`define SSP_A_BAUD    8'h08
`define SSP_A_STAT    8'h0c
`define SSP_A_MASK    8'h10
`define SSP_A_RXCF    8'h14

// control fields
`define SSP_C_SYNC    0
`define SSP_C_WL_HI   2
`define SSP_C_WL_LO   1
`define SSP_C_PEN     3
`define SSP_C_PODD    4
`define SSP_C_STOP2   5
`define SSP_C_MSB     6
`define SSP_C_HWFC    7
`define SSP_C_IRDA    8
`define SSP_C_RS485   9
`define SSP_C_TXEN    10
`define SSP_C_RXEN    11

// word length codes
`define SSP_WL_7      2'd0
`define SSP_WL_9      2'd2

// status fields
`define SSP_S_PERR    0
`define SSP_S_FERR    1
`define SSP_S_OVR     2
`define SSP_S_BRK     3
`define SSP_S_TXE     4
`define SSP_S_RXTH    5
`define SSP_S_RTO     6
`define SSP_S_TBUSY   8
`define SSP_S_RXNE    9
`define SSP_S_TXFULL  10

// rx config fields
`define SSP_R_THR_HI  3
`define SSP_R_TO_HI   15
`define SSP_R_TO_LO   8

// reset values
`define SSP_RST_CTRL  16'h0c02
`define SSP_RST_BAUD  16'h0009
`define SSP_RST_MASK  7'h00
`define SSP_RST_RXCF  16'h2004

// timing in divider ticks
`define SSP_OSR_ASYNC 5'd16
`define SSP_OSR_SYNC  5'd8
`define SSP_IR_PULSE  5'd3
`define SSP_IR_HOLD   5'd16

`define SSP_FIFO_DEPTH 4'd8

`endif

// *** core/ssp_fifo.v ***
`include "ssp_consts.vh"

module ssp_fifo (
    input  wire       clk,
    input  wire       resetn,
    input  wire       en,
    input  wire       push,
    input  wire [8:0] wdata,
    input  wire       pop,
    output reg  [8:0] head_q,
    output reg  [3:0] cnt_q
);
    reg  [8:0] mem [0:7];
    reg  [2:0] wp_q;
    reg  [2:0] rp_q;
    wire       do_wr = en & push & (cnt_q != `SSP_FIFO_DEPTH);
    wire       do_rd = en & pop & (cnt_q != 4'd0);
    wire [2:0] rp_n  = rp_q + {2'b00, do_rd};

    always @(posedge clk) begin
        if (do_wr)
            mem[wp_q] <= wdata;
    end

    // head is registered; bypass covers a write into a drained queue
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wp_q   <= 3'd0;
            rp_q   <= 3'd0;
            cnt_q  <= 4'd0;
            head_q <= 9'h000;
        end else if (en) begin
            if (do_wr)
                wp_q <= wp_q + 3'd1;
            rp_q <= rp_n;
            if (do_wr && !do_rd)
                cnt_q <= cnt_q + 4'd1;
            else if (do_rd && !do_wr)
                cnt_q <= cnt_q - 4'd1;
            head_q <= (do_wr && wp_q == rp_n) ? wdata : mem[rp_n];
        end
    end
endmodule // ssp_fifo

// *** core/ssp_top.v ***
// Function
// R1: async or clocked sync mode by config
// R2: bit rate up to pclk/16 or pclk/8
// R3: transmitter and receiver run independently
// R4: seven, eight or nine data bits
// R5: even, odd or no parity
// R6: one or two stop bits sent
// R7: lsb first or msb first order
// R8: report parity, overrun and framing errors
// R9: automatic rts/cts hardware flow control
// R10: optional infrared sir encode and decode
// R11: rs485 driver enable around transmissions
// R12: eight-entry transmit and receive queues
// R13: four interrupt sources; the code has seven, one per sticky status flag, each maskable
// R14: status register with error and break flags
// R15: receive idle time-out interrupt
// R16: full queue drops new char, flags overrun
`include "ssp_consts.vh"

module ssp_top (
    input  wire        clk,
    input  wire        resetn,
    input  wire        ce,
    input  wire [7:0]  addr,
    input  wire [15:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [15:0] rdata_q,
    output reg         irq_q,
    input  wire        rxd,
    input  wire        cts_n,
    output reg         txd_q,
    output reg         sck_q,
    output reg         rts_n_q,
    output reg         de_q
);
    function [3:0] ssp_nbits;
        input [1:0] wl;
        begin
            if (wl == `SSP_WL_7)
                ssp_nbits = 4'd7;
            else if (wl == `SSP_WL_9)
                ssp_nbits = 4'd9;
            else
                ssp_nbits = 4'd8;
        end
    endfunction

    // msb-first reversal within the active width; its own inverse
    function [8:0] ssp_order;
        input [8:0] d;
        input [3:0] n;
        input       msb;
        integer     i;
        begin
            ssp_order = 9'h000;
            for (i = 0; i < 9; i = i + 1) begin
                if (i < n)
                    ssp_order[i] = msb ? d[n - 1 - i] : d[i];
            end
        end
    endfunction

    function ssp_par;
        input [8:0] d;
        input [3:0] n;
        input       odd;
        integer     i;
        begin
            ssp_par = odd;
            for (i = 0; i < 9; i = i + 1) begin
                if (i < n)
                    ssp_par = ssp_par ^ d[i];
            end
        end
    endfunction

    reg  [15:0] ctrl_q;
    reg  [15:0] baud_q;
    reg  [6:0]  mask_q;
    reg  [15:0] rxcf_q;
    reg  [6:0]  stat_q;
    reg  [6:0]  set_d;
    reg  [15:0] div_q;

    wire       sync_m = ctrl_q[`SSP_C_SYNC];
    wire [3:0] nd     = ssp_nbits(ctrl_q[`SSP_C_WL_HI:`SSP_C_WL_LO]);
    wire       pen    = ctrl_q[`SSP_C_PEN];
    wire       podd   = ctrl_q[`SSP_C_PODD];
    wire       msb    = ctrl_q[`SSP_C_MSB];
    wire       hwfc   = ctrl_q[`SSP_C_HWFC];
    wire       irda   = ctrl_q[`SSP_C_IRDA];
    wire [3:0] thr    = rxcf_q[`SSP_R_THR_HI:0];
    wire [7:0] to_val = rxcf_q[`SSP_R_TO_HI:`SSP_R_TO_LO];

    // one divider paces both directions; div 0 gives the top rate
    wire       tick = (div_q == baud_q); // R2
    wire [4:0] osr  = sync_m ? `SSP_OSR_SYNC : `SSP_OSR_ASYNC; // R1 R2
    wire [4:0] half = {1'b0, osr[4:1]};

    // register port decode
    wire wr_data = wr & (addr == `SSP_A_DATA);
    wire rd_data = rd & (addr == `SSP_A_DATA);
    wire rd_stat = rd & (addr == `SSP_A_STAT);

    // queues
    wire [8:0] tx_head;
    wire [3:0] tx_cnt;
    wire [8:0] rx_head;
    wire [3:0] rx_cnt;
    wire       tx_full  = (tx_cnt == `SSP_FIFO_DEPTH);
    wire       rx_full  = (rx_cnt == `SSP_FIFO_DEPTH);
    wire       tx_empty = (tx_cnt == 4'd0);
    wire       rx_empty = (rx_cnt == 4'd0);

    // transmitter
    reg        tx_busy_q;
    reg [12:0] tx_sh_q;
    reg [3:0]  tx_left_q;
    reg [4:0]  tx_ph_q;
    reg [12:0] tx_fr;
    reg [8:0]  tx_ord;
    integer    k;

    // a new char waits for cts; one already on the line finishes
    wire tx_go = ce & tick & ~tx_busy_q & ctrl_q[`SSP_C_TXEN] & ~tx_empty
               & (~hwfc | ~cts_n); // R9 R3
    wire [3:0] tx_tot = 4'd2 + nd + {3'd0, pen}
                      + {3'd0, ctrl_q[`SSP_C_STOP2]}; // R6 R4

    always @* begin
        tx_ord = ssp_order(tx_head, nd, msb); // R7
        tx_fr  = 13'h1fff;
        tx_fr[0] = 1'b0;
        for (k = 0; k < 9; k = k + 1) begin
            if (k < nd)
                tx_fr[k + 1] = tx_ord[k]; // R4
        end
        if (pen)
            tx_fr[nd + 1] = ssp_par(tx_head, nd, podd); // R5
    end

    wire tx_bit_end = tick & tx_busy_q & (tx_ph_q == osr - 5'd1);

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_busy_q <= 1'b0;
            tx_sh_q   <= 13'h1fff;
            tx_left_q <= 4'd0;
            tx_ph_q   <= 5'd0;
        end else if (ce) begin
            if (tx_go) begin
                tx_busy_q <= 1'b1;
                tx_sh_q   <= tx_fr;
                tx_left_q <= tx_tot;
                tx_ph_q   <= 5'd0;
            end else if (tx_bit_end) begin
                tx_ph_q   <= 5'd0;
                tx_sh_q   <= {1'b1, tx_sh_q[12:1]};
                tx_left_q <= tx_left_q - 4'd1;
                if (tx_left_q == 4'd1)
                    tx_busy_q <= 1'b0;
            end else if (tick && tx_busy_q) begin
                tx_ph_q <= tx_ph_q + 5'd1;
            end
        end
    end

    // receiver line: sir pulse stretched over one bit time
    reg  [4:0] ir_q;
    wire       line = irda ? (ir_q == 5'd0) : rxd; // R10

    reg        rx_busy_q;
    reg [4:0]  rx_ph_q;
    reg [3:0]  rx_n_q;
    reg [12:0] rx_sh_q;
    reg [8:0]  rx_raw;
    reg [8:0]  rx_dat;
    reg        rx_pbit;
    // own loop index: a shared one would wake the tx block forever
    integer    j;

    wire [3:0] rx_tot  = 4'd2 + nd + {3'd0, pen}; // R4
    wire       rx_smp  = ce & tick & rx_busy_q & (rx_ph_q == half);
    wire       rx_done = rx_smp & (rx_n_q == rx_tot - 4'd1);
    wire       rx_push = rx_done & ~rx_full; // R16

    always @* begin
        rx_raw = 9'h000;
        for (j = 0; j < 9; j = j + 1) begin
            if (j < nd)
                rx_raw[j] = rx_sh_q[j + 1];
        end
        rx_pbit = rx_sh_q[nd + 1];
        rx_dat  = ssp_order(rx_raw, nd, msb); // R7
    end

    wire rx_perr = pen & (rx_pbit != ssp_par(rx_dat, nd, podd)); // R5
    wire rx_brk  = ~line & (rx_raw == 9'h000) & ~(pen & rx_pbit);

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ir_q      <= 5'd0;
            rx_busy_q <= 1'b0;
            rx_ph_q   <= 5'd0;
            rx_n_q    <= 4'd0;
            rx_sh_q   <= 13'h0000;
        end else if (ce) begin
            if (rxd)
                ir_q <= `SSP_IR_HOLD;
            else if (tick && ir_q != 5'd0)
                ir_q <= ir_q - 5'd1;
            if (!rx_busy_q) begin
                if (tick && ctrl_q[`SSP_C_RXEN] && !line) begin // R3
                    rx_busy_q <= 1'b1;
                    rx_ph_q   <= 5'd0;
                    rx_n_q    <= 4'd0;
                end
            end else if (tick) begin
                rx_ph_q <= (rx_ph_q == osr - 5'd1) ? 5'd0
                         : rx_ph_q + 5'd1;
                if (rx_smp) begin
                    rx_sh_q[rx_n_q] <= line;
                    rx_n_q <= rx_n_q + 4'd1;
                    // a start bit gone high by mid-bit is a glitch
                    if ((rx_n_q == 4'd0 && line) || rx_done)
                        rx_busy_q <= 1'b0;
                end
            end
        end
    end

    // idle time-out counts ticks in sixteenths of a bit unit
    reg  [11:0] to_q;
    wire [11:0] to_lim = {to_val, 4'h0};
    wire        to_hit = (to_val != 8'h00) & (to_q == to_lim - 12'd1);

    always @(posedge clk or negedge resetn) begin
        if (!resetn)
            to_q <= 12'd0;
        else if (ce) begin
            if (rx_empty || rx_busy_q || rd_data)
                to_q <= 12'd0; // R15
            else if (tick && to_q != to_lim)
                to_q <= to_q + 12'd1;
        end
    end

    // sticky events
    always @* begin
        set_d = 7'h00;
        set_d[`SSP_S_PERR] = rx_done & rx_perr; // R8
        set_d[`SSP_S_FERR] = rx_done & ~line & ~rx_brk; // R8
        set_d[`SSP_S_OVR]  = rx_done & rx_full; // R16 R8
        set_d[`SSP_S_BRK]  = rx_done & rx_brk; // R14
        set_d[`SSP_S_TXE]  = tx_go & (tx_cnt == 4'd1); // R13
        set_d[`SSP_S_RXTH] = rx_push & (rx_cnt == thr - 4'd1); // R13
        set_d[`SSP_S_RTO]  = ce & tick & to_hit & ~rx_empty
                           & ~rx_busy_q; // R15 R13
    end

    // register file
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q  <= `SSP_RST_CTRL;
            baud_q  <= `SSP_RST_BAUD;
            mask_q  <= `SSP_RST_MASK;
            rxcf_q  <= `SSP_RST_RXCF;
            stat_q  <= 7'h00;
            rdata_q <= 16'h0000;
            irq_q   <= 1'b0;
            div_q   <= 16'h0000;
        end else if (ce) begin
            div_q <= tick ? 16'h0000 : div_q + 16'h0001;
            if (wr) begin
                case (addr)
                    `SSP_A_CTRL: ctrl_q <= wdata; // R1
                    `SSP_A_BAUD: begin
                        baud_q <= wdata;
                        div_q  <= 16'h0000;
                    end
                    `SSP_A_MASK: mask_q <= wdata[6:0];
                    `SSP_A_RXCF: rxcf_q <= wdata;
                    default: ;
                endcase
            end
            // a set arriving with the clearing read survives
            stat_q <= (rd_stat ? 7'h00 : stat_q) | set_d; // R14
            rdata_q <= 16'h0000;
            if (rd) begin
                case (addr)
                    `SSP_A_DATA: rdata_q <= {7'h00, rx_head};
                    `SSP_A_CTRL: rdata_q <= ctrl_q;
                    `SSP_A_BAUD: rdata_q <= baud_q;
                    `SSP_A_STAT: rdata_q <= {5'h00, tx_full, ~rx_empty,
                                             tx_busy_q, 1'b0,
                                             stat_q}; // R14
                    `SSP_A_MASK: rdata_q <= {9'h000, mask_q};
                    `SSP_A_RXCF: rdata_q <= rxcf_q;
                    default:     rdata_q <= 16'h0000;
                endcase
            end
            irq_q <= |(stat_q & mask_q); // R13
        end
    end

    // line outputs
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            txd_q   <= 1'b1;
            sck_q   <= 1'b0;
            rts_n_q <= 1'b0;
            de_q    <= 1'b0;
        end else if (ce) begin
            if (irda)
                txd_q <= tx_busy_q & ~tx_sh_q[0]
                       & (tx_ph_q < `SSP_IR_PULSE); // R10
            else
                txd_q <= tx_busy_q ? tx_sh_q[0] : 1'b1;
            // clock rises mid-bit so the far end samples there
            sck_q <= sync_m & tx_busy_q & (tx_ph_q >= half); // R1
            // drop rts one slot early: a char may already be inbound
            rts_n_q <= hwfc & (rx_cnt >= `SSP_FIFO_DEPTH - 4'd1); // R9
            de_q <= ctrl_q[`SSP_C_RS485] & (tx_busy_q | tx_go); // R11
        end
    end

    ssp_fifo u_txq ( // R12
        .clk    (clk),
        .resetn (resetn),
        .en     (ce),
        .push   (wr_data & ~tx_full),
        .wdata  (wdata[8:0]),
        .pop    (tx_go),
        .head_q (tx_head),
        .cnt_q  (tx_cnt)
    );

    ssp_fifo u_rxq ( // R12
        .clk    (clk),
        .resetn (resetn),
        .en     (ce),
        .push   (rx_push),
        .wdata  (rx_dat),
        .pop    (rd_data),
        .head_q (rx_head),
        .cnt_q  (rx_cnt)
    );
endmodule // ssp_top

// *** tb/sasp_props.sv ***
`include "ssp_consts.vh"
module sasp_props (
    input logic        clk,
    input logic        resetn,
    input logic        ce,
    input logic [7:0]  addr,
    input logic [15:0] wdata,
    input logic        wr,
    input logic        rd,
    input logic [15:0] rdata_q,
    input logic        irq_q,
    input logic        txd_q,
    input logic        sck_q,
    input logic        rts_n_q,
    input logic        de_q
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] ctrl_q;
    logic [15:0] baud_q;
    logic [6:0]  mask_q;
    // shadow of the config writes, the only state the port lets us see
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= `SSP_RST_CTRL;
            baud_q <= `SSP_RST_BAUD;
            mask_q <= `SSP_RST_MASK;
        end else if (wr && ce) begin
            if (addr == `SSP_A_CTRL) ctrl_q <= wdata;
            if (addr == `SSP_A_BAUD) baud_q <= wdata;
            if (addr == `SSP_A_MASK) mask_q <= wdata[6:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_rdata_idle: assert property (
        !rd && ce |=> rdata_q == 16'h0000)
        else $error("read data not zero outside read slot");
    a_unmapped_rd: assert property (
        rd && ce && addr == 8'h18 |=> rdata_q == 16'h0000)
        else $error("unmapped read not zero");
    a_ctrl_back: assert property (
        wr && addr == `SSP_A_CTRL ##2 rd && !wr && addr == `SSP_A_CTRL
        |=> rdata_q[11:0] == $past(wdata[11:0], 3))
        else $error("control readback differs");
    a_irq_masked: assert property (
        mask_q == 7'h00 && $past(mask_q) == 7'h00 |-> !irq_q)
        else $error("interrupt while fully masked");
    a_de_frame: assert property (
        $rose(de_q) && !ctrl_q[8] |=> $fell(txd_q))
        else $error("start bit does not follow driver enable");
    a_de_off: assert property (
        !ctrl_q[9] && !$past(ctrl_q[9]) |-> !de_q)
        else $error("driver enable outside rs485 mode");
    a_rts_off: assert property (
        !ctrl_q[7] && !$past(ctrl_q[7]) |-> !rts_n_q)
        else $error("rts deasserted without flow control");
    a_sck_quiet: assert property (
        !ctrl_q[0] && !$past(ctrl_q[0]) |-> !sck_q)
        else $error("bit clock toggles in async mode");
    // fastest divider: any low level lasts a full 16-tick bit
    a_fast_bit: assert property (
        $fell(txd_q) && baud_q == 16'h0000 && !ctrl_q[0] && !ctrl_q[8]
        |-> (!txd_q) [*8] ##1 (!txd_q) [*8])
        else $error("async bit shorter than 16 clocks");
    c_irq: cover property ($rose(irq_q));
    c_de: cover property ($rose(de_q));
    c_rts: cover property ($rose(rts_n_q));
endmodule // sasp_props

// *** tb/sasp_peer.sv ***
module sasp_peer (
    input  logic clk,
    input  logic txd,
    output logic rxd,
    output logic cts_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] cap;
    int          ncap;
    initial begin
        rxd = 1'b1;
        cts_n = 1'b0;
        cap = 12'h000;
        ncap = 0;
    end
    // mid-bit sampling; assumes the fastest divider, 16 clocks a bit
    always begin
        @(negedge txd);
        repeat (8) @(posedge clk);
        for (int i = 0; i < 12; i++) begin
            cap[i] = txd;
            repeat (16) @(posedge clk);
        end
        ncap++;
    end
    // one idle clock after each frame avoids a double drive of rxd
    task automatic send(input logic [11:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            rxd <= f[i];
            repeat (16) @(posedge clk);
        end
        rxd <= 1'b1;
        @(posedge clk);
    endtask
endmodule // sasp_peer

// *** tb/test_sync_async_serial_port.sv ***
`include "ssp_consts.vh"
module test_sync_async_serial_port;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk;
    logic        resetn;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata_q;
    logic        irq_q;
    logic        rxd;
    logic        cts_n;
    logic        txd_q;
    logic        sck_q;
    logic        rts_n_q;
    logic        de_q;
    logic [15:0] v;
    int          err_total;
    int          tests_run;
    int          cyc;
    int          n0;
    int          n1;
    int          de_len;
    int          sck_n;
    int          tx_up;
    int          tx_hi;
    logic        ce;
    logic        sck_p;
    logic        txd_p;
    logic [7:0]  ra [5] = '{8'h04, 8'h08, 8'h10, 8'h14, 8'h18};
    logic [15:0] rv [5] = '{16'h0c02, 16'h0009, 16'h0000, 16'h2004, 16'h0000};
    logic [15:0] tc [4] = '{16'h0e02, 16'h0e4a, 16'h0e38, 16'h0e2c};
    // driver enable spans 16 clocks a bit plus the lead-in clock
    logic [15:0] dl [4] = '{16'h00a1, 16'h00b1, 16'h00b1, 16'h00d1};
    logic [8:0]  td [4] = '{9'h0a5, 9'h035, 9'h04b, 9'h1c3};
    ssp_top u_dut (.clk(clk), .resetn(resetn), .ce(ce), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q), .irq_q(irq_q),
        .rxd(rxd), .cts_n(cts_n), .txd_q(txd_q), .sck_q(sck_q),
        .rts_n_q(rts_n_q), .de_q(de_q));
    sasp_peer u_peer (.clk(clk), .txd(txd_q), .rxd(rxd), .cts_n(cts_n));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata_q;
    endtask
    function automatic logic [11:0] frm(input logic [8:0] d,
                                        input logic [15:0] c);
        logic [11:0] f;
        logic        p;
        int          nb;
        nb = 7 + int'(c[2:1]);
        f = 12'hfff;
        f[0] = 1'b0;
        p = c[4];
        for (int i = 0; i < nb; i++) begin
            f[1 + i] = c[6] ? d[nb - 1 - i] : d[i];
            p = p ^ d[i];
        end
        if (c[3]) f[nb + 1] = p;
        return f;
    endfunction
    task automatic wait_cap(input int n);
        for (int i = 0; i < 400 && u_peer.ncap == n; i++) @(posedge clk);
    endtask
    task automatic rx_stat(input logic [11:0] f, input int n,
                           input logic [15:0] m, input logic [15:0] e);
        u_peer.send(f, n);
        repeat (4) @(posedge clk);
        rreg(`SSP_A_STAT, v);
        chk(v & m, e);
        rreg(`SSP_A_DATA, v);
    endtask
    task automatic wrap_up();
        $display("checks=%0d errors=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // run is a few thousand cycles; the ceiling leaves ample margin
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            wrap_up();
        end
    end
    // edge and level counts of line outputs, read as deltas
    always @(posedge clk) begin
        sck_p <= sck_q;
        txd_p <= txd_q;
        if (de_q) de_len <= de_len + 1;
        if (sck_q && !sck_p) sck_n <= sck_n + 1;
        if (txd_q && !txd_p) tx_up <= tx_up + 1;
        if (txd_q) tx_hi <= tx_hi + 1;
    end
    initial begin
        resetn = 1'b0;
        addr = 8'h00;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        ce = 1'b1;
        err_total = 0;
        tests_run = 0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rreg(ra[i], v);
            chk(v, rv[i]);
        end
        @(posedge clk);
        ce <= 1'b0;
        wreg(`SSP_A_MASK, 16'h007f);
        ce <= 1'b1;
        rreg(`SSP_A_MASK, v);
        chk(v, 16'h0000);
        wreg(`SSP_A_BAUD, 16'h0000);
        wreg(`SSP_A_MASK, 16'h007f);
        wreg(`SSP_A_RXCF, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            wreg(`SSP_A_CTRL, tc[i]);
            rreg(`SSP_A_CTRL, v);
            chk(v, tc[i]);
            n0 = u_peer.ncap;
            n1 = de_len;
            wreg(`SSP_A_DATA, {7'h00, td[i]});
            wait_cap(n0);
            chk({4'h0, u_peer.cap}, {4'h0, frm(td[i], tc[i])});
            repeat (16) @(posedge clk);
            chk(16'(de_len - n1), dl[i]);
        end
        wreg(`SSP_A_CTRL, 16'h0c82);
        u_peer.cts_n <= 1'b1;
        n0 = u_peer.ncap;
        wreg(`SSP_A_DATA, 16'h0011);
        repeat (100) @(posedge clk);
        chk({15'h0000, txd_q}, 16'h0001);
        u_peer.cts_n <= 1'b0;
        wait_cap(n0);
        chk({4'h0, u_peer.cap}, {4'h0, frm(9'h011, 16'h0c82)});
        rreg(`SSP_A_STAT, v);
        chk(v & 16'h0010, 16'h0010);
        repeat (2) @(posedge clk);
        chk({15'h0000, irq_q}, 16'h0000);
        u_peer.send(frm(9'h05a, 16'h0c82), 10);
        repeat (4) @(posedge clk);
        chk({15'h0000, irq_q}, 16'h0001);
        rreg(`SSP_A_STAT, v);
        chk(v & 16'h027f, 16'h0220);
        rreg(`SSP_A_DATA, v);
        chk(v & 16'h01ff, 16'h005a);
        wreg(`SSP_A_CTRL, 16'h0c8a);
        rx_stat(frm(9'h033, 16'h0c8a) ^ 12'h200, 11, 16'h0007, 16'h0001);
        wreg(`SSP_A_CTRL, 16'h0c82);
        rx_stat(frm(9'h081, 16'h0c82) & 12'hdff, 10, 16'h0007, 16'h0002);
        rx_stat(12'h000, 10, 16'h000a, 16'h0008);
        rreg(`SSP_A_DATA, v);
        for (int i = 0; i < 9; i++) begin
            if (i == 8) chk({15'h0000, rts_n_q}, 16'h0001);
            u_peer.send(frm(9'(i), 16'h0c82), 10);
        end
        repeat (4) @(posedge clk);
        rreg(`SSP_A_STAT, v);
        chk(v & 16'h0004, 16'h0004);
        for (int i = 0; i < 8; i++) begin
            rreg(`SSP_A_DATA, v);
            chk(v & 16'h01ff, 16'(i));
        end
        repeat (2) @(posedge clk);
        chk({15'h0000, rts_n_q}, 16'h0000);
        rreg(`SSP_A_STAT, v);
        chk(v & 16'h0200, 16'h0000);
        wreg(`SSP_A_RXCF, 16'h0101);
        u_peer.send(frm(9'h0c3, 16'h0c82), 10);
        repeat (60) @(posedge clk);
        rreg(`SSP_A_STAT, v);
        chk(v & 16'h0040, 16'h0040);
        wreg(`SSP_A_CTRL, 16'h0c03);
        n0 = sck_n;
        wreg(`SSP_A_DATA, 16'h0055);
        repeat (120) @(posedge clk);
        chk(16'(sck_n - n0), 16'h000a);
        // sir: one 3-clock pulse per zero bit, idle low
        wreg(`SSP_A_CTRL, 16'h0d02);
        repeat (2) @(posedge clk);
        n0 = tx_up;
        n1 = tx_hi;
        wreg(`SSP_A_DATA, 16'h000f);
        repeat (200) @(posedge clk);
        chk(16'(tx_up - n0), 16'h0005);
        chk(16'(tx_hi - n1), 16'h000f);
        wrap_up();
    end
endmodule // test_sync_async_serial_port
bind ssp_top sasp_props u_props (.clk(clk), .resetn(resetn), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
    .irq_q(irq_q), .txd_q(txd_q), .sck_q(sck_q), .rts_n_q(rts_n_q),
    .de_q(de_q));
